// >>> logic/mcab_pkg.sv
package mcab_pkg;
    localparam logic [7:0] OFS_REMAP = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h80;
    localparam logic [7:0] OFS_IRQ_EN = 8'h84;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h88;
    localparam logic [7:0] OFS_REMAP_STATE = 8'h8C;

    localparam int BIT_UNDEF = 0;
    localparam int BIT_MIS = 1;
    localparam int SIZE_LSB = 8;
    localparam int TYPE_LSB = 10;
    localparam int BIT_DMA = 16;
    localparam int BIT_CPU = 17;
    localparam int BIT_SV_DMA = 24;
    localparam int BIT_SV_CPU = 25;
    localparam int IRQ_DMA = 0;
    localparam int IRQ_CPU = 1;

    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] TYP_READ = 2'h0;
    localparam logic [1:0] TYP_WRITE = 2'h1;
    localparam logic [1:0] TYP_FETCH = 2'h2;

    localparam logic [3:0] AREA_INTERNAL = 4'h0;
    localparam logic [3:0] AREA_PERIPH = 4'hF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// >>> logic/mcab_misalign.sv
module mcab_misalign
    import mcab_pkg::*;
(
    input wire logic [1:0] size,
    input wire logic [1:0] addr_lo,
    input wire logic is_cpu_fetch,
    output logic misaligned
);
    // Prefetch pipeline makes fetch address checks meaningless, so CPU fetches skip it; DMA fetches are still checked
    always_comb
    begin
        misaligned = 1'b0;
        if (!is_cpu_fetch)
        begin
            if (size == SZ_WORD)
                misaligned = (addr_lo != 2'h0);
            else if (size == SZ_HALF)
                misaligned = addr_lo[0];
        end
    end
endmodule // mcab_misalign

// >>> logic/mcab_ctrl.sv
module mcab_ctrl
    import mcab_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic acc_valid,
    input wire logic acc_from_cpu,
    input wire logic [31:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic [1:0] acc_type,
    input wire logic acc_int_undef,
    input wire logic first_fc_security,
    input wire logic [1:0] first_fc_general_nonvolatile_bits,
    output logic abort_out,
    output logic remap_active,
    output logic irq,
    output logic flash_security,
    output logic [1:0] flash_general_nonvolatile_bits
);
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_bad_width
        $error("mcab_ctrl: ADDR_W must be 8 to 32");
    end

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic aw_held_q, w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_hs, w_hs, ar_hs, do_write;
    logic aw_held_d, w_held_d, bvalid_d, rvalid_d;
    logic [7:0] ar_addr;
    logic addr_hi_zero_r;

    logic remap_q;
    logic undef_q, mis_q, dma_q, cpu_q, sv_dma_q, sv_cpu_q;
    logic [1:0] size_q, type_q;
    logic [31:0] abort_addr_q;
    logic [1:0] irq_stat_q, irq_en_q;
    logic abort_q, irq_q, sec_q;
    logic [1:0] general_nonvolatile_bits_q;

    logic misaligned, undef, abort_ev, status_read;
    logic [31:0] status_word;

    assign aw_hs = s_axi_awvalid && awready_q;
    assign w_hs = s_axi_wvalid && wready_q;
    assign ar_hs = s_axi_arvalid && arready_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign aw_held_d = aw_hs || (aw_held_q && !do_write);
    assign w_held_d = w_hs || (w_held_q && !do_write);
    assign bvalid_d = do_write || (bvalid_q && !s_axi_bready);
    assign rvalid_d = ar_hs || (rvalid_q && !s_axi_rready);
    assign ar_addr = s_axi_araddr[7:0];
    if (ADDR_W > 8)
    begin : g_hi
        assign addr_hi_zero_r = (s_axi_araddr[ADDR_W-1:8] == '0);
    end
    else
    begin : g_nohi
        assign addr_hi_zero_r = 1'b1;
    end

    // Write channel: address and data taken in either order, then one response
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= WORD_RST;
            w_strb_q <= 4'h0;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready_q <= !aw_held_d;
            wready_q <= !w_held_d;
            bvalid_q <= bvalid_d;
            if (aw_hs)
                aw_addr_q <= s_axi_awaddr[7:0];
            if (w_hs)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Upper address bits beyond 8 are dropped on write capture; decode covers 8 bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bresp_q <= RESP_OKAY;
        else if (do_write)
        begin
            case (aw_addr_q)
                OFS_REMAP, OFS_STATUS, OFS_ADDR, OFS_IRQ_STAT, OFS_IRQ_EN,
                OFS_IRQ_CLR, OFS_REMAP_STATE: bresp_q <= RESP_OKAY;
                default: bresp_q <= RESP_SLVERR;
            endcase
        end
    end

    assign status_word = {6'h00, sv_cpu_q, sv_dma_q, 6'h00, cpu_q, dma_q,
                          4'h0, type_q, size_q, 6'h00, mis_q, undef_q};
    assign status_read = ar_hs && addr_hi_zero_r && (ar_addr == OFS_STATUS);

    // Read channel; the returned status is the value before the read clears it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= WORD_RST;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_hs)
            begin
                rresp_q <= RESP_OKAY;
                rdata_q <= WORD_RST;
                if (!addr_hi_zero_r)
                    rresp_q <= RESP_SLVERR;
                else
                begin
                    case (ar_addr)
                        OFS_REMAP, OFS_IRQ_CLR: rdata_q <= WORD_RST;
                        OFS_STATUS: rdata_q <= status_word;
                        OFS_ADDR: rdata_q <= abort_addr_q;
                        OFS_IRQ_STAT: rdata_q <= {30'h0, irq_stat_q};
                        OFS_IRQ_EN: rdata_q <= {30'h0, irq_en_q};
                        OFS_REMAP_STATE: rdata_q <= {31'h0, remap_q};
                        default: rresp_q <= RESP_SLVERR;
                    endcase
                end
            end
        end
    end

    // Remap toggles on every write of one with the lane 0 strobe set; reset leaves original mapping
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            remap_q <= 1'b0;
        else if (do_write && aw_addr_q == OFS_REMAP && w_strb_q[0] && w_data_q[0])
            remap_q <= !remap_q;
    end

    mcab_misalign u_misalign (
        .size(acc_size),
        .addr_lo(acc_addr[1:0]),
        .is_cpu_fetch(acc_from_cpu && acc_type == TYP_FETCH),
        .misaligned(misaligned)
    );

    assign undef = acc_int_undef ||
                   (acc_addr[31:28] != AREA_INTERNAL && acc_addr[31:28] != AREA_PERIPH);
    assign abort_ev = acc_valid && (undef || misaligned);

    // All fields captured from the same failing access
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            undef_q <= 1'b0;
            mis_q <= 1'b0;
            size_q <= SZ_BYTE;
            type_q <= TYP_READ;
            dma_q <= 1'b0;
            cpu_q <= 1'b0;
            abort_addr_q <= WORD_RST;
        end
        else if (abort_ev)
        begin
            undef_q <= undef;
            mis_q <= misaligned;
            size_q <= acc_size;
            type_q <= acc_type;
            dma_q <= !acc_from_cpu;
            cpu_q <= acc_from_cpu;
            abort_addr_q <= acc_addr;
        end
    end

    // History bits: a new abort in the reading cycle survives the clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sv_dma_q <= 1'b0;
            sv_cpu_q <= 1'b0;
        end
        else
        begin
            if (abort_ev && !acc_from_cpu)
                sv_dma_q <= 1'b1;
            else if (status_read)
                sv_dma_q <= 1'b0;
            if (abort_ev && acc_from_cpu)
                sv_cpu_q <= 1'b1;
            else if (status_read)
                sv_cpu_q <= 1'b0;
        end
    end

    // Broadcast regardless of source; the DMA master simply ignores it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            abort_q <= 1'b0;
        else
            abort_q <= abort_ev;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat_q <= 2'h0;
            irq_en_q <= 2'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (abort_ev && (i == IRQ_CPU) == acc_from_cpu)
                    irq_stat_q[i] <= 1'b1;
                else if (do_write && aw_addr_q == OFS_IRQ_CLR && w_strb_q[0] && w_data_q[i])
                    irq_stat_q[i] <= 1'b0;
            end
            if (do_write && aw_addr_q == OFS_IRQ_EN && w_strb_q[0])
                irq_en_q <= w_data_q[1:0];
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    // Second flash controller carries no such bits; the first one's apply to both
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sec_q <= 1'b0;
            general_nonvolatile_bits_q <= 2'h0;
        end
        else
        begin
            sec_q <= first_fc_security;
            general_nonvolatile_bits_q <= first_fc_general_nonvolatile_bits;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign abort_out = abort_q;
    assign remap_active = remap_q;
    assign irq = irq_q;
    assign flash_security = sec_q;
    assign flash_general_nonvolatile_bits = general_nonvolatile_bits_q;

    a_remap_toggle: assert property (@(posedge clk) disable iff (rst)
        (do_write && aw_addr_q == OFS_REMAP && w_strb_q[0] && w_data_q[0])
        |=> remap_q != $past(remap_q)) else $error("remap did not toggle");
    a_remap_zero: assert property (@(posedge clk) disable iff (rst)
        (do_write && aw_addr_q == OFS_REMAP && !w_data_q[0]) |=> $stable(remap_q))
        else $error("remap changed on zero write");
    a_cause_flags: assert property (@(posedge clk) disable iff (rst)
        abort_ev |=> undef_q == $past(undef) && mis_q == $past(misaligned))
        else $error("abort cause flags wrong");
    a_size_type: assert property (@(posedge clk) disable iff (rst)
        abort_ev |=> size_q == $past(acc_size) && type_q == $past(acc_type)
        && abort_addr_q == $past(acc_addr)) else $error("abort fields not captured");
    a_source_bits: assert property (@(posedge clk) disable iff (rst)
        abort_ev |=> cpu_q == $past(acc_from_cpu) && dma_q != cpu_q)
        else $error("abort source bits wrong");
    a_saved_hold: assert property (@(posedge clk) disable iff (rst)
        !status_read ##1 1'b1 |-> (!$fell(sv_dma_q) && !$fell(sv_cpu_q)))
        else $error("saved bit lost without read");
    a_saved_clear: assert property (@(posedge clk) disable iff (rst)
        (status_read && !abort_ev) |=> !sv_dma_q && !sv_cpu_q)
        else $error("saved bits not cleared by read");
    a_addr_read: assert property (@(posedge clk) disable iff (rst)
        (ar_hs && ar_addr == OFS_ADDR && addr_hi_zero_r) |=> rdata_q == $past(abort_addr_q))
        else $error("abort address read wrong");
    a_abort_out: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> abort_q == $past(abort_ev)) else $error("abort output mismatch");
    a_fetch_exempt: assert property (@(posedge clk) disable iff (rst)
        (acc_valid && acc_from_cpu && acc_type == TYP_FETCH && !undef) |=> !abort_q)
        else $error("cpu fetch aborted for alignment");
    a_flash_shared: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> sec_q == $past(first_fc_security) && general_nonvolatile_bits_q == $past(first_fc_general_nonvolatile_bits))
        else $error("flash shared bits not following first controller");
endmodule // mcab_ctrl

// >>> testbench/mcab_masters.sv
module mcab_masters (
    input wire logic clk,
    output logic acc_valid,
    output logic acc_from_cpu,
    output logic [31:0] acc_addr,
    output logic [1:0] acc_size,
    output logic [1:0] acc_type,
    output logic acc_int_undef
);
    timeunit 1ns;
    timeprecision 1ps;

    // No abort input: the DMA master ignores aborts, the core's reaction is out of scope
    initial
    begin
        acc_valid = 1'b0;
        acc_from_cpu = 1'b0;
        acc_addr = 32'h0000_0000;
        acc_size = 2'h0;
        acc_type = 2'h0;
        acc_int_undef = 1'b0;
    end

    // One access per call; afterwards the bus shows inverted values with acc_int_undef low so stale data cannot match
    task automatic issue(input logic cpu, input logic [31:0] a, input logic [1:0] sz,
        input logic [1:0] ty, input logic ud);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_from_cpu <= cpu;
        acc_addr <= a;
        acc_size <= sz;
        acc_type <= ty;
        acc_int_undef <= ud;
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_from_cpu <= ~cpu;
        acc_addr <= ~a;
        acc_size <= ~sz;
        acc_type <= ~ty;
        acc_int_undef <= 1'b0;
    endtask
endmodule // mcab_masters

// >>> testbench/tb_bus_abort_status_and_remap.sv
module tb_bus_abort_status_and_remap;
    import mcab_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic acc_valid, acc_from_cpu, acc_int_undef;
    logic [31:0] acc_addr;
    logic [1:0] acc_size, acc_type;
    logic first_fc_security;
    logic [1:0] first_fc_general_nonvolatile_bits, flash_general_nonvolatile_bits;
    logic abort_out, remap_active, irq, flash_security;
    int miscompares, comparisons, cycles;
    logic [31:0] exp_st, exp_ad;
    logic [1:0] exp_sv;

    mcab_ctrl #(.ADDR_W(8)) uut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .acc_valid(acc_valid), .acc_from_cpu(acc_from_cpu),
        .acc_addr(acc_addr), .acc_size(acc_size), .acc_type(acc_type),
        .acc_int_undef(acc_int_undef), .first_fc_security(first_fc_security),
        .first_fc_general_nonvolatile_bits(first_fc_general_nonvolatile_bits), .abort_out(abort_out), .remap_active(remap_active),
        .irq(irq), .flash_security(flash_security), .flash_general_nonvolatile_bits(flash_general_nonvolatile_bits));

    mcab_masters masters (.clk(clk), .acc_valid(acc_valid), .acc_from_cpu(acc_from_cpu),
        .acc_addr(acc_addr), .acc_size(acc_size), .acc_type(acc_type),
        .acc_int_undef(acc_int_undef));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; a hang ends here
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // No cycle limit here: only the bench timeout ends a wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Saved bits clear on the status read, so the expectation drops them too
    task automatic status_chk();
        rc(OFS_STATUS, exp_st | {6'h00, exp_sv, 24'h0}, RESP_OKAY);
        exp_sv = 2'h0;
        rc(OFS_ADDR, exp_ad, RESP_OKAY);
    endtask

    task automatic abort_case(input logic cpu, input logic [31:0] a, input logic [1:0] sz,
        input logic [1:0] ty, input logic ud, input logic look);
        logic un, mis;
        un = (a[31:28] != AREA_INTERNAL && a[31:28] != AREA_PERIPH) || ud;
        mis = !(cpu && ty == TYP_FETCH) && ((sz == SZ_WORD && a[1:0] != 2'h0)
            || (sz == SZ_HALF && a[0]));
        masters.issue(cpu, a, sz, ty, ud);
        @(negedge clk);
        chk({31'h0, abort_out}, {31'h0, un || mis});
        if (un || mis)
        begin
            exp_st = {14'h0, cpu, !cpu, 4'h0, ty, sz, 6'h00, mis, un};
            exp_ad = a;
            exp_sv = exp_sv | (cpu ? 2'h2 : 2'h1);
        end
        if (look) status_chk();
    endtask

    task automatic reset_values();
        rc(OFS_STATUS, WORD_RST, RESP_OKAY);
        rc(OFS_ADDR, WORD_RST, RESP_OKAY);
        rc(OFS_REMAP_STATE, 32'h0, RESP_OKAY);
    endtask

    task automatic remap_toggle();
        logic [1:0] r;
        wr(OFS_REMAP, 32'hFFFF_FFFE, r);
        chk({31'h0, remap_active}, 32'h0);
        wr(OFS_REMAP, 32'h1, r);
        chk({31'h0, remap_active}, 32'h1);
        rc(OFS_REMAP_STATE, 32'h1, RESP_OKAY);
        rc(OFS_REMAP, 32'h0, RESP_OKAY);
        wr(OFS_REMAP, 32'h1, r);
        chk({31'h0, remap_active}, 32'h0);
        // Lane 0 strobe low: the command bit is not written
        s_axi_wstrb <= 4'hE;
        wr(OFS_REMAP, 32'h1, r);
        s_axi_wstrb <= 4'hF;
        chk({31'h0, remap_active}, 32'h0);
    endtask

    // Reset in mid-run returns remap, status, abort address and remap state to their reset values
    task automatic reset_midrun();
        logic [1:0] r;
        wr(OFS_REMAP, 32'h1, r);
        chk({31'h0, remap_active}, 32'h1);
        abort_case(1'b1, 32'h2000_0004, SZ_WORD, TYP_READ, 1'b0, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({31'h0, remap_active}, 32'h0);
        exp_st = 32'h0;
        exp_ad = 32'h0;
        exp_sv = 2'h0;
        reset_values();
    endtask

    task automatic unmapped_access();
        logic [1:0] r;
        rc(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFS_STATUS, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rc(OFS_STATUS, 32'h0, RESP_OKAY);
    endtask

    task automatic abort_table();
        abort_case(1'b0, 32'h0000_0002, SZ_WORD, TYP_READ, 1'b0, 1'b1);
        abort_case(1'b1, 32'h2000_0000, SZ_HALF, TYP_WRITE, 1'b0, 1'b1);
        abort_case(1'b1, 32'h0000_0001, SZ_WORD, TYP_FETCH, 1'b0, 1'b1);
        abort_case(1'b0, 32'hF000_0001, SZ_HALF, TYP_FETCH, 1'b0, 1'b1);
        abort_case(1'b1, 32'h0000_0003, SZ_BYTE, TYP_READ, 1'b1, 1'b1);
        abort_case(1'b1, 32'h3000_0006, SZ_WORD, TYP_WRITE, 1'b0, 1'b1);
    endtask

    task automatic saved_history();
        abort_case(1'b0, 32'h0000_0001, SZ_HALF, TYP_WRITE, 1'b0, 1'b0);
        abort_case(1'b1, 32'h5000_0000, SZ_BYTE, TYP_READ, 1'b0, 1'b0);
        status_chk();
        status_chk();
    endtask

    task automatic irq_flow();
        logic [1:0] r;
        rc(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_EN, 32'h3, r);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_CLR, 32'h1, r);
        rc(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        wr(OFS_IRQ_CLR, 32'h2, r);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic flash_bits();
        @(posedge clk);
        first_fc_security <= 1'b1;
        first_fc_general_nonvolatile_bits <= 2'h2;
        repeat (3) @(posedge clk);
        chk({29'h0, flash_security, flash_general_nonvolatile_bits}, 32'h6);
        first_fc_security <= 1'b0;
        first_fc_general_nonvolatile_bits <= 2'h1;
        repeat (3) @(posedge clk);
        chk({29'h0, flash_security, flash_general_nonvolatile_bits}, 32'h1);
    endtask

    initial
    begin
        rst = 1'b1;
        cycles = 0;
        miscompares = 0;
        comparisons = 0;
        exp_st = 32'h0;
        exp_ad = 32'h0;
        exp_sv = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        first_fc_security = 1'b0;
        first_fc_general_nonvolatile_bits = 2'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reset_values();
        remap_toggle();
        unmapped_access();
        abort_table();
        saved_history();
        irq_flow();
        flash_bits();
        reset_midrun();
        results();
    end
endmodule // tb_bus_abort_status_and_remap
